/* File: cg_clock_gen.sv */
`timescale 1ns/1ps
//
// Contract
// - PLL output divided by 2, 4, 6 or 8 from a two-bit select.
// - Prescaled peripheral clock divided by 2n, n 0..15, n zero passes through.
// - Base clock divided from its source by 2, 3, 4 or 6.
// - CPU clock divided from base clock by 1 to 4.
// - Peripheral bus clock divided from base clock by 2 to 4.
// - Internal oscillator stopped after reset until its enable bit is one.
// - Internal oscillator clock usable at once, no stabilisation wait.
// - Internal oscillator runs at 125 kHz, with a divide-by-four output.
// - Base source select zero picks the PLL clock.
// - PLL keeps running despite full-stop request while base source select is zero; a one can stop it while the mux still picks the PLL.
// - Wait mode halts base, CPU and peripheral bus clocks.
// - Wait mode freezes the CPU and the watchdog.
// - Main, sub, PLL and internal oscillator clocks keep running in wait mode.
// - A fixed divide-by-256 peripheral clock is provided.
module cg_clock_gen (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_b,
  // Source clock pins
  input  wire logic           pll_clock_in,
  input  wire logic           main_clock_in,
  input  wire logic           sub_clock_in,
  // Control from software
  input  cg_pkg::cg_cfg_t     cfg,
  input  wire logic           internal_osc_enable,
  input  wire logic           full_stop_request,
  input  wire logic           wait_mode,
  // Generated clocks
  output cg_pkg::cg_clocks_t  clocks,
  output logic                sub_clock_out,
  output logic                main_clock_out,
  // Run controls
  output logic                pll_run,
  output logic                cpu_run,
  output logic                watchdog_run
);

  ////////////////////////////////////////////////////////////////////////////////
  // Ratio decoding.

  function automatic logic [cg_pkg::RATIO_W-1:0] post_ratio(input logic [1:0] sel);
    post_ratio = {6'h00, sel, 1'b0} + 9'h002;
  endfunction : post_ratio

  function automatic logic [cg_pkg::RATIO_W-1:0] base_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    base_ratio = 9'h002;
      2'h1:    base_ratio = 9'h003;
      2'h2:    base_ratio = 9'h004;
      default: base_ratio = 9'h006;
    endcase
  endfunction : base_ratio

  function automatic logic [cg_pkg::RATIO_W-1:0] cpu_ratio(input logic [1:0] sel);
    cpu_ratio = {7'h00, sel} + 9'h001;
  endfunction : cpu_ratio

  function automatic logic [cg_pkg::RATIO_W-1:0] bus_ratio(input logic [1:0] sel);
    // The top code repeats the slowest ratio since only three ratios exist.
    bus_ratio = (sel == 2'h3) ? 9'h004 : ({7'h00, sel} + 9'h002);
  endfunction : bus_ratio

  function automatic logic [cg_pkg::RATIO_W-1:0] pre_ratio(input logic [3:0] n);
    pre_ratio = (n == 4'h0) ? cg_pkg::RATIO_ONE : {4'h0, n, 1'b0};
  endfunction : pre_ratio

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sampling: three stages, a change counts once the second and third agree.

  logic [2:0] pin_in;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] lvl_r;
  logic [2:0] rise_r;

  assign pin_in = {sub_clock_in, main_clock_in, pll_clock_in};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= cg_pkg::SYNC_RESET;
      sync2_r <= cg_pkg::SYNC_RESET;
      sync3_r <= cg_pkg::SYNC_RESET;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_r  <= cg_pkg::SYNC_RESET;
      rise_r <= cg_pkg::SYNC_RESET;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          lvl_r[i] <= sync3_r[i];
        end
        rise_r[i] <= (sync2_r[i] == sync3_r[i]) && sync3_r[i] && !lvl_r[i];
      end
    end
  end

  // Source clocks other than the base chain are never gated by wait mode.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_clock_out <= 1'b0;
      sub_clock_out  <= 1'b0;
    end else begin
      main_clock_out <= lvl_r[1];
      sub_clock_out  <= lvl_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PLL post divider and base source selection.

  logic pll_div_clk;
  logic pll_div_tick;
  logic src_lvl;
  logic src_tick;
  logic sel_pll_r;

  cg_divider u_post_div (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (rise_r[0]),
    .src_lvl  (lvl_r[0]),
    .run      (1'b1),
    .ratio    (post_ratio(cfg.pll_post_divider_sel)),
    .div_clk  (pll_div_clk),
    .div_tick (pll_div_tick)
  );

  // The select follows software only while both candidates are low, so no sliver reaches
  // the base divider; a stalled source would hold the old choice.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_pll_r <= 1'b1;
    end else if (!pll_div_clk && !lvl_r[1]) begin
      sel_pll_r <= !cfg.base_source_select;
    end
  end

  assign src_lvl  = sel_pll_r ? pll_div_clk  : lvl_r[1];
  assign src_tick = sel_pll_r ? pll_div_tick : rise_r[1];

  // On a full-stop request the PLL stops once software selects the main clock, even while it still feeds the base clock.
  assign pll_run = !(full_stop_request && cfg.base_source_select);

  ////////////////////////////////////////////////////////////////////////////////
  // Base chain, halted in wait mode; ratios live in cfg and survive the halt.

  logic base_clk;
  logic base_tick;
  logic base_run;
  logic cpu_clk;
  logic bus_clk;

  // In wait mode the base clock keeps ticking until both children have ended their high
  // phase; stopping it earlier would leave a child frozen high.
  assign base_run = !wait_mode || cpu_clk || bus_clk;

  cg_divider u_base_div (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (src_tick),
    .src_lvl  (src_lvl),
    .run      (base_run),
    .ratio    (base_ratio(cfg.base_divider_sel)),
    .div_clk  (base_clk),
    .div_tick (base_tick)
  );

  cg_divider u_cpu_div (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (base_tick),
    .src_lvl  (base_clk),
    .run      (!wait_mode),
    .ratio    (cpu_ratio(cfg.cpu_divider_sel)),
    .div_clk  (cpu_clk),
    .div_tick ()
  );

  cg_divider u_bus_div (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (base_tick),
    .src_lvl  (base_clk),
    .run      (!wait_mode),
    .ratio    (bus_ratio(cfg.periph_bus_divider_sel)),
    .div_clk  (bus_clk),
    .div_tick ()
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_run      <= 1'b0;
      watchdog_run <= 1'b0;
    end else begin
      cpu_run      <= !wait_mode;
      watchdog_run <= !wait_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral taps run from the selected source and ignore wait mode.

  logic pre_clk;
  logic fixed_div256_clock_clk;

  cg_divider u_pre_div (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (src_tick),
    .src_lvl  (src_lvl),
    .run      (1'b1),
    .ratio    (pre_ratio(cfg.prescaler_divide_count)),
    .div_clk  (pre_clk),
    .div_tick ()
  );

  cg_divider u_fixed_div256_clock_div (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (src_tick),
    .src_lvl  (src_lvl),
    .run      (1'b1),
    .ratio    (cg_pkg::RATIO_DIV256),
    .div_clk  (fixed_div256_clock_clk),
    .div_tick ()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Internal oscillator, timed from the system clock.

  logic [cg_pkg::OSC_CNT_W-1:0] osc_cnt_r;
  logic                         osc_clk_r;
  logic                         osc_tick_r;
  logic                         osc_wrap;

  assign osc_wrap = (osc_cnt_r == cg_pkg::OSC_CNT_W'(cg_pkg::OSC_HALF_CYC - 1));

  // It starts on the enable at once; a disable lets the high phase finish first.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_cnt_r  <= '0;
      osc_clk_r  <= 1'b0;
      osc_tick_r <= 1'b0;
    end else if (internal_osc_enable || osc_clk_r) begin
      osc_cnt_r  <= osc_wrap ? '0 : osc_cnt_r + 1'b1;
      osc_clk_r  <= osc_wrap ? !osc_clk_r : osc_clk_r;
      osc_tick_r <= osc_wrap && !osc_clk_r && internal_osc_enable;
    end else begin
      osc_cnt_r  <= '0;
      osc_tick_r <= 1'b0;
    end
  end

  logic qtr_clk;

  cg_divider u_osc_quarter (
    .clk      (clk),
    .rst_b    (rst_b),
    .src_tick (osc_tick_r),
    .src_lvl  (osc_clk_r),
    .run      (internal_osc_enable),
    .ratio    (cg_pkg::RATIO_QUARTER),
    .div_clk  (qtr_clk),
    .div_tick ()
  );

  // One driver for the whole carrier, in the member order of the package type.
  assign clocks = {base_clk, cpu_clk, bus_clk, pll_div_clk,
                   pre_clk, fixed_div256_clock_clk, osc_clk_r, qtr_clk};

endmodule : cg_clock_gen

/* File: cg_pkg.sv */
package cg_pkg;

  // Clock rates: the system clock samples every source and paces the internal oscillator.
  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
  localparam int unsigned OSC_FREQ_HZ   = 125_000;
  localparam int unsigned OSC_HALF_CYC  = CLK_FREQ_HZ / (2 * OSC_FREQ_HZ);

  localparam int unsigned RATIO_W       = 9;
  localparam int unsigned OSC_CNT_W     = 10;

  // Fixed ratios of the tap dividers.
  localparam logic [8:0]  RATIO_ONE     = 9'h001;
  localparam logic [8:0]  RATIO_QUARTER = 9'h004;
  localparam logic [8:0]  RATIO_DIV256  = 9'h100;

  // Values after reset.
  localparam logic [1:0]  SEL_RESET     = 2'h0;
  localparam logic [3:0]  CNT_RESET     = 4'h0;
  localparam logic [2:0]  SYNC_RESET    = 3'h0;

  typedef struct packed {
    logic       base_source_select;
    logic [1:0] pll_post_divider_sel;
    logic [1:0] base_divider_sel;
    logic [1:0] cpu_divider_sel;
    logic [1:0] periph_bus_divider_sel;
    logic [3:0] prescaler_divide_count;
  } cg_cfg_t;

  typedef struct packed {
    logic base_clock;
    logic cpu_clock;
    logic periph_bus_clock;
    logic pll_divided_clock;
    logic divided_prescaler_clock;
    logic fixed_div256_clock;
    logic internal_osc_clock;
    logic internal_osc_quarter_clock;
  } cg_clocks_t;

endpackage : cg_pkg

/* File: cg_divider.sv */
`timescale 1ns/1ps
// Divides a stream of source rising-edge ticks by a ratio, producing a clock level and a tick.
module cg_divider (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Source
  input  wire logic                      src_tick,
  input  wire logic                      src_lvl,
  // Control
  input  wire logic                      run,
  input  wire logic [cg_pkg::RATIO_W-1:0] ratio,
  // Divided output
  output logic                           div_clk,
  output logic                           div_tick
);

  logic [cg_pkg::RATIO_W-1:0] cur_r;
  logic [cg_pkg::RATIO_W-1:0] cnt_r;
  logic [cg_pkg::RATIO_W-1:0] cnt_nxt;
  logic                       wrap;
  logic                       bypass;

  assign bypass  = (cur_r == cg_pkg::RATIO_ONE);
  assign wrap    = (cnt_r == cur_r - cg_pkg::RATIO_ONE);
  assign cnt_nxt = wrap ? '0 : cnt_r + cg_pkg::RATIO_ONE;

  ////////////////////////////////////////////////////////////////////////////////
  // A new ratio is taken only at a period boundary, so no phase is ever cut short.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_r <= cg_pkg::RATIO_ONE;
    end else if (src_tick && wrap && (run || bypass)) begin
      cur_r <= ratio;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r    <= '0;
      div_clk  <= 1'b0;
      div_tick <= 1'b0;
    end else if (bypass) begin
      // A rise needs a source tick while running, so a start or a stop never clips a phase.
      cnt_r    <= '0;
      div_clk  <= src_lvl & (div_clk | (run & src_tick));
      div_tick <= run & src_tick;
    end else if (src_tick && (run || !wrap)) begin
      // When stopped the period is finished first and the count parks on its last tick,
      // so a restart begins a whole new period and no phase is cut short.
      cnt_r    <= cnt_nxt;
      div_clk  <= (cnt_nxt < ((cur_r + cg_pkg::RATIO_ONE) >> 1));
      div_tick <= run & wrap;
    end else begin
      div_tick <= 1'b0;
    end
  end

endmodule : cg_divider

/* File: cg_clock_gen_sva.sv */
`timescale 1ns/1ps
module cg_clock_gen_sva (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_b,
  // Inputs
  input wire logic         pll_clock_in,
  input wire logic         main_clock_in,
  input wire logic         sub_clock_in,
  input cg_pkg::cg_cfg_t   cfg,
  input wire logic         internal_osc_enable,
  input wire logic         full_stop_request,
  input wire logic         wait_mode,
  // Outputs
  input cg_pkg::cg_clocks_t clocks,
  input wire logic         sub_clock_out,
  input wire logic         main_clock_out,
  input wire logic         pll_run,
  input wire logic         cpu_run,
  input wire logic         watchdog_run
);
  logic [9:0]  osc_hi_r;
  logic [11:0] qtr_hi_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) osc_hi_r <= '0;
    else osc_hi_r <= clocks.internal_osc_clock ? osc_hi_r + 10'h001 : 10'h000;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) qtr_hi_r <= '0;
    else qtr_hi_r <= clocks.internal_osc_quarter_clock ? qtr_hi_r + 12'h001 : 12'h000;
  end

  // Wait must be seen for a few cycles so a period already under way may end first.
  sequence s_wait_held;
    wait_mode [*4];
  endsequence

  a_pll_run_keep: assert property (pll_run == !(full_stop_request && cfg.base_source_select))
    else $error("pll_run wrong");
  a_wait_cpu_halt: assert property (wait_mode |=> !cpu_run && !watchdog_run)
    else $error("cpu or watchdog runs in wait");
  a_wake_cpu_run: assert property (!wait_mode |=> cpu_run && watchdog_run)
    else $error("cpu or watchdog stopped");
  a_osc_stay_off: assert property (!internal_osc_enable && !clocks.internal_osc_clock
    |=> !clocks.internal_osc_clock) else $error("osc started unasked");
  a_osc_fast_start: assert property ($rose(internal_osc_enable)
    |-> ##[1:401] clocks.internal_osc_clock) else $error("osc slow to start");
  a_osc_half_len: assert property ($fell(clocks.internal_osc_clock)
    |-> osc_hi_r == cg_pkg::OSC_HALF_CYC) else $error("osc high phase length");
  a_qtr_high_len: assert property ($fell(clocks.internal_osc_quarter_clock)
    |-> qtr_hi_r >= 12'h63F && qtr_hi_r <= 12'h641) else $error("quarter high length");
  a_wait_base_low: assert property (s_wait_held ##0 !clocks.base_clock && !clocks.cpu_clock
    && !clocks.periph_bus_clock |=> !clocks.base_clock) else $error("base clock runs in wait");
  a_wait_cpu_low: assert property (s_wait_held ##0 !clocks.cpu_clock
    |=> !clocks.cpu_clock) else $error("cpu clock runs in wait");
  a_wait_bus_low: assert property (s_wait_held ##0 !clocks.periph_bus_clock
    |=> !clocks.periph_bus_clock) else $error("bus clock runs in wait");
  a_main_follow: assert property ($rose(main_clock_in)
    |-> ##[3:6] $rose(main_clock_out)) else $error("main clock not followed");
endmodule : cg_clock_gen_sva

bind cg_clock_gen cg_clock_gen_sva cg_clock_gen_sva_inst (.*);

/* File: cg_clock_gen_tb.sv */
`timescale 1ns/1ps
module cg_clock_gen_tb;
  logic               clk;
  logic               rst_b;
  logic               pll_clock_in;
  logic               main_clock_in;
  logic               sub_clock_in;
  cg_pkg::cg_cfg_t    cfg;
  logic               internal_osc_enable;
  logic               full_stop_request;
  logic               wait_mode;
  cg_pkg::cg_clocks_t clocks;
  logic               sub_clock_out;
  logic               main_clock_out;
  logic               pll_run;
  logic               cpu_run;
  logic               watchdog_run;
  logic [9:0]         v;
  int                 cyc;
  int                 n_errors;
  int                 n_compared;

  assign v = {clocks, main_clock_out, sub_clock_out};

  cg_clock_gen cg_clock_gen_inst (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pins are far slower than clk so the pin filter can follow them.
  always @(negedge clk) begin
    cyc <= cyc + 1;
    pll_clock_in <= (cyc % 16) < 8;
    main_clock_in <= (cyc % 20) < 10;
    sub_clock_in <= (cyc % 24) < 12;
  end

  task automatic final_report;
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %0d exp %0d", $time, got, exp);
    end
  endtask : chk

  // Counts cycles until the next rise of bit b of v.
  task automatic rise(input int b, output int n);
    n = 0;
    while (v[b] !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    while (v[b] !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) begin
      n_errors++;
      $display("BAD %0t no edge", $time);
      final_report();
    end
  endtask : rise

  // The first period after a ratio change may still use the old ratio, so it is skipped.
  task automatic per(input int b, output int n);
    repeat (3) rise(b, n);
  endtask : per

  task automatic t_dividers;
    int n;
    int bv[4] = '{2, 3, 4, 6};
    int qv[4] = '{2, 3, 4, 4};
    for (int s = 0; s < 4; s++) begin
      cfg.pll_post_divider_sel = s[1:0];
      per(6, n);
      chk(n, 32 * s + 32);
    end
    cfg.pll_post_divider_sel = 2'h0;
    for (int s = 0; s < 4; s++) begin
      cfg.base_divider_sel = s[1:0];
      per(9, n);
      chk(n, 32 * bv[s]);
    end
    cfg.base_divider_sel = 2'h0;
    for (int s = 0; s < 4; s++) begin
      cfg.cpu_divider_sel = s[1:0];
      cfg.periph_bus_divider_sel = s[1:0];
      per(8, n);
      chk(n, 64 * s + 64);
      per(7, n);
      chk(n, 64 * qv[s]);
    end
  endtask : t_dividers

  task automatic t_presc;
    int n;
    int a[3] = '{0, 1, 15};
    for (int i = 0; i < 3; i++) begin
      cfg.prescaler_divide_count = a[i][3:0];
      per(5, n);
      chk(n, (a[i] == 0) ? 32 : 64 * a[i]);
    end
    per(4, n);
    chk(n, 32 * 256);
  endtask : t_presc

  task automatic t_source;
    int n;
    full_stop_request = 1'b1;
    @(negedge clk);
    chk(pll_run, 1);
    cfg.base_source_select = 1'b1;
    @(negedge clk);
    chk(pll_run, 0);
    per(9, n);
    chk(n, 40);
    cfg.base_source_select = 1'b0;
    full_stop_request = 1'b0;
    per(9, n);
    chk(n, 64);
  endtask : t_source

  task automatic t_wait;
    int n;
    cfg.cpu_divider_sel = 2'h1;
    cfg.periph_bus_divider_sel = 2'h0;
    per(8, n);
    wait_mode = 1'b1;
    repeat (300) @(negedge clk);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (v[9:7] !== 3'h0) n++;
    end
    chk(n, 0);
    chk({cpu_run, watchdog_run}, 0);
    per(6, n);
    chk(n, 32);
    per(1, n);
    chk(n, 20);
    per(0, n);
    chk(n, 24);
    wait_mode = 1'b0;
    per(9, n);
    chk(n, 64);
    per(8, n);
    chk(n, 128);
  endtask : t_wait

  task automatic t_osc;
    int n;
    internal_osc_enable = 1'b1;
    rise(3, n);
    chk(n <= 401, 1);
    per(3, n);
    chk(n, 2 * cg_pkg::OSC_HALF_CYC);
    per(2, n);
    chk(n >= 3199 && n <= 3201, 1);
    internal_osc_enable = 1'b0;
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    n = 0;
    repeat (900) begin
      @(negedge clk);
      if (v[3] !== 1'b0) n++;
    end
    chk(n, 0);
  endtask : t_osc

  initial begin
    cyc = 0;
    rst_b = 1'b0;
    pll_clock_in = 1'b0;
    main_clock_in = 1'b0;
    sub_clock_in = 1'b0;
    cfg = '0;
    internal_osc_enable = 1'b0;
    full_stop_request = 1'b0;
    wait_mode = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    t_dividers();
    t_presc();
    t_source();
    t_wait();
    t_osc();
    final_report();
  end
endmodule : cg_clock_gen_tb
